// [rtl/tpzc_comp.sv]
// Phase angle and zero-sequence compensation of two winding currents.
// Assumes same-clock samples with a one-cycle strobe
// and settings written over AHB-Lite.
//
// What this block does
// - Reference is lowest delta/zigzag winding, else one.
// - Reference winding gets zero-angle combination.
// - Angle is reference minus winding; ACB swaps operands.
// - Compensation completes before downstream use.
// - Zero-sequence removed when grounded within zone; 30 and 210 lag remove it always.
// - Fixed combinations; B and C rotate phase A's.
// - Zero: two thirds minus thirds, or pass.
// - 30 lag: (A minus C) over root three.
// - 60 lag: minus C, or zone variant.
// - 90 lag: root-three forms per grounding.
// - 120 lag: B, or zone variant.
// - 150 lag: root-three forms per grounding.
// - 180 lag: negate, or zone variant.
// - 210 lag: (C minus A) over root three.
// - 240 lag: C, or zone variant.
// - 270 lag: root-three forms per grounding.
// - 300 lag: minus B, or zone variant.
// - 330 lag: root-three forms per grounding.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps

module tpzc_comp
    import tpzc_pkg::*;
(
    // Clock and reset.
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // AHB-Lite slave port.
    input  wire logic         hsel,
    input  wire logic [7:0]   haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // Uncompensated samples from the front end.
    input  wire logic         samp_valid,
    input  wire tpzc_phase_s  samp_w1,
    input  wire tpzc_phase_s  samp_w2,
    // Compensated samples to the differential stage.
    output logic              comp_valid,
    output tpzc_cphase_s      comp_w1,
    output tpzc_cphase_s      comp_w2
);

    // Modular difference of two angles in 30 degree steps.
    function automatic logic [3:0] ang_sub(input logic [3:0] x, input logic [3:0] y);
        logic [4:0] xm;
        logic [4:0] ym;
        logic [4:0] t;
        xm = {1'b0, x} % ANG_STEPS;
        ym = {1'b0, y} % ANG_STEPS;
        t  = xm + ANG_STEPS - ym;
        if (t >= ANG_STEPS) begin
            t = t - ANG_STEPS;
        end
        return t[3:0];
    endfunction

    // Weights for compensated phase A, by lag angle and grounding.
    function automatic tpzc_coef_s coef_lookup(input logic [3:0] ang, input logic in_zone);
        tpzc_coef_s k;
        k = '{K_ONE, K_ZERO, K_ZERO};
        unique case (ang)
            4'h0: begin
                // Zero shift: pass, or strip the zero-sequence part.
                if (in_zone) k = '{K_TWO_THIRD, -K_THIRD, -K_THIRD};
                else k = '{K_ONE, K_ZERO, K_ZERO};
            end
            4'h1: begin
                // Same form under both groundings.
                k = '{K_INV_RT3, K_ZERO, -K_INV_RT3};
            end
            4'h2: begin
                if (in_zone) k = '{K_THIRD, K_THIRD, -K_TWO_THIRD};
                else k = '{K_ZERO, K_ZERO, -K_ONE};
            end
            4'h3: begin
                if (in_zone) k = '{K_ZERO, K_INV_RT3, -K_INV_RT3};
                else k = '{-K_INV_RT3, K_ZERO, -K_TWO_RT3};
            end
            4'h4: begin
                if (in_zone) k = '{-K_THIRD, K_TWO_THIRD, -K_THIRD};
                else k = '{K_ZERO, K_ONE, K_ZERO};
            end
            4'h5: begin
                if (in_zone) k = '{-K_INV_RT3, K_INV_RT3, K_ZERO};
                else k = '{-K_TWO_RT3, K_ZERO, -K_INV_RT3};
            end
            4'h6: begin
                if (in_zone) k = '{-K_TWO_THIRD, K_THIRD, K_THIRD};
                else k = '{-K_ONE, K_ZERO, K_ZERO};
            end
            4'h7: begin
                // Same form under both groundings.
                k = '{-K_INV_RT3, K_ZERO, K_INV_RT3};
            end
            4'h8: begin
                if (in_zone) k = '{-K_THIRD, -K_THIRD, K_TWO_THIRD};
                else k = '{K_ZERO, K_ZERO, K_ONE};
            end
            4'h9: begin
                if (in_zone) k = '{K_ZERO, -K_INV_RT3, K_INV_RT3};
                else k = '{K_INV_RT3, K_ZERO, K_TWO_RT3};
            end
            4'ha: begin
                if (in_zone) k = '{K_THIRD, -K_TWO_THIRD, K_THIRD};
                else k = '{K_ZERO, -K_ONE, K_ZERO};
            end
            4'hb: begin
                if (in_zone) k = '{K_INV_RT3, -K_INV_RT3, K_ZERO};
                else k = '{K_TWO_RT3, K_ZERO, K_INV_RT3};
            end
            default: begin
                // Angle codes above eleven never leave the angle logic.
                k = '{K_ONE, K_ZERO, K_ZERO};
            end
        endcase
        return k;
    endfunction

    // Weighted sum of three currents.
    function automatic logic signed [OUT_W-1:0] mac(input tpzc_coef_s k,
        input logic signed [CUR_W-1:0] x,
        input logic signed [CUR_W-1:0] y,
        input logic signed [CUR_W-1:0] z);
        logic signed [SUM_W-1:0] s;
        s = SUM_W'(x * k.ka) + SUM_W'(y * k.kb) + SUM_W'(z * k.kc);
        s = s >>> COEF_FRAC;
        return s[OUT_W-1:0];
    endfunction

    // Compensates one winding; B and C rotate A's weights.
    function automatic tpzc_cphase_s compensate(input tpzc_phase_s i,
        input logic [3:0]  ang,
        input logic        in_zone);
        tpzc_coef_s   k;
        tpzc_cphase_s o;
        k   = coef_lookup(ang, in_zone);
        o.a = mac(k, i.a, i.b, i.c);
        o.b = mac(k, i.b, i.c, i.a);
        o.c = mac(k, i.c, i.a, i.b);
        return o;
    endfunction

    // Settings held by software.
    tpzc_wcfg_s   cfg_w1_q;     // Winding one settings.
    tpzc_wcfg_s   cfg_w2_q;     // Winding two settings.
    logic         rot_acb_q;    // Rotation ACB when set.
    // Settings after the write of the data phase.
    tpzc_wcfg_s   cfg_w1_d;
    tpzc_wcfg_s   cfg_w2_d;
    logic         rot_acb_d;
    // Derived reference and angles.
    logic         ref_w2_q;     // Reference is winding two when set.
    logic [3:0]   cmp_w1_q;     // Compensation angle of winding one.
    logic [3:0]   cmp_w2_q;     // Compensation angle of winding two.
    logic         recalc_q;     // A setting changed last cycle.
    logic         ref_w2_d;
    logic [3:0]   ref_ang;
    // Bus state.
    logic         wr_pend_q;    // A write data phase is under way.
    logic [7:0]   wr_addr_q;    // Byte address of that write.
    logic         addr_take;    // An address phase is taken this cycle.
    logic         cfg_write;    // A setting register is written this cycle.
    logic [31:0]  rd_word;      // Read value for the address phase.
    // Output registers.
    logic         comp_valid_q;
    tpzc_cphase_s comp_w1_q;
    tpzc_cphase_s comp_w2_q;

    // NONSEQ or SEQ with the bus ready is taken.
    assign addr_take = hsel && htrans[1] && hready;
    assign cfg_write = wr_pend_q && ((wr_addr_q == REG_CFG_W1) ||
                                     (wr_addr_q == REG_CFG_W2) ||
                                     (wr_addr_q == REG_CTRL));

    // Applies the data of a pending write, so reads see it at once.
    always_comb begin
        cfg_w1_d  = cfg_w1_q;
        cfg_w2_d  = cfg_w2_q;
        rot_acb_d = rot_acb_q;
        if (wr_pend_q) begin
            unique case (wr_addr_q)
                REG_CFG_W1: begin
                    cfg_w1_d = tpzc_wcfg_s'(hwdata[CFG_GND_BIT:CFG_CONN_LSB]);
                end
                REG_CFG_W2: begin
                    cfg_w2_d = tpzc_wcfg_s'(hwdata[CFG_GND_BIT:CFG_CONN_LSB]);
                end
                REG_CTRL: begin
                    rot_acb_d = hwdata[CTRL_ACB_BIT];
                end
                default: begin
                    // Writes elsewhere are dropped.
                    rot_acb_d = rot_acb_q;
                end
            endcase
        end
    end

    // Builds the read word; unmapped addresses read as zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case ({haddr[7:2], 2'b00})
            REG_CFG_W1: begin
                rd_word[CFG_GND_BIT:CFG_CONN_LSB] = cfg_w1_d;
            end
            REG_CFG_W2: begin
                rd_word[CFG_GND_BIT:CFG_CONN_LSB] = cfg_w2_d;
            end
            REG_CTRL: begin
                rd_word[CTRL_ACB_BIT] = rot_acb_d;
            end
            REG_STATUS: begin
                rd_word[STAT_REF_BIT] = ref_w2_q;
                rd_word[STAT_CMP1_LSB+3:STAT_CMP1_LSB] = cmp_w1_q;
                rd_word[STAT_CMP2_LSB+3:STAT_CMP2_LSB] = cmp_w2_q;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // Captures each address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_take && hwrite;
            if (addr_take) begin
                wr_addr_q <= {haddr[7:2], 2'b00};
            end
        end
    end

    // Read data is loaded in the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata <= rd_word;
        end
    end

    // The slave never stalls and always answers OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Stores the settings; every write is a word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_w1_q  <= WCFG_RST;
            cfg_w2_q  <= WCFG_RST;
            rot_acb_q <= 1'b0;
            recalc_q  <= 1'b0;
        end else begin
            cfg_w1_q  <= cfg_w1_d;
            cfg_w2_q  <= cfg_w2_d;
            rot_acb_q <= rot_acb_d;
            recalc_q  <= cfg_write;
        end
    end

    // Picks the first non-wye winding as reference, else winding one.
    always_comb begin
        ref_w2_d = 1'b0;
        if ((cfg_w1_q.conn != CONN_DELTA) && (cfg_w1_q.conn != CONN_ZIGZAG) &&
            ((cfg_w2_q.conn == CONN_DELTA) || (cfg_w2_q.conn == CONN_ZIGZAG))) begin
            ref_w2_d = 1'b1;
        end
        ref_ang = ref_w2_d ? cfg_w2_q.angle : cfg_w1_q.angle;
    end

    // Reference and angles change only after a setting write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_w2_q <= 1'b0;
            cmp_w1_q <= 4'h0;
            cmp_w2_q <= 4'h0;
        end else if (recalc_q) begin
            ref_w2_q <= ref_w2_d;
            if (rot_acb_q) begin
                cmp_w1_q <= ang_sub(cfg_w1_q.angle, ref_ang);
                cmp_w2_q <= ang_sub(cfg_w2_q.angle, ref_ang);
            end else begin
                cmp_w1_q <= ang_sub(ref_ang, cfg_w1_q.angle);
                cmp_w2_q <= ang_sub(ref_ang, cfg_w2_q.angle);
            end
            // The reference winding always gets angle zero.
            if (!ref_w2_d) begin
                cmp_w1_q <= 4'h0;
            end else begin
                cmp_w2_q <= 4'h0;
            end
        end
    end

    // Compensates both windings once per sample strobe.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_valid_q <= 1'b0;
            comp_w1_q    <= '0;
            comp_w2_q    <= '0;
        end else begin
            comp_valid_q <= samp_valid;
            if (samp_valid) begin
                comp_w1_q <= compensate(samp_w1, cmp_w1_q, cfg_w1_q.gnd_in_zone);
                comp_w2_q <= compensate(samp_w2, cmp_w2_q, cfg_w2_q.gnd_in_zone);
            end
        end
    end

    // Outputs come straight from their registers.
    assign comp_valid = comp_valid_q;
    assign comp_w1    = comp_w1_q;
    assign comp_w2    = comp_w2_q;

endmodule

// [rtl/tpzc_pkg.sv]
// Shared constants, types and coefficient tables for the phase and
// zero-sequence compensation block.
// Assumes a single processing clock and two-winding current samples.
package tpzc_pkg;

    // Width of an uncompensated phase current sample (signed).
    localparam int CUR_W     = 16;
    // Width of a compensated phase current (signed, two bits of growth).
    localparam int OUT_W     = 18;
    // Fraction bits of the fixed-point coefficients.
    localparam int COEF_FRAC = 16;
    // Width of a signed coefficient.
    localparam int COEF_W    = 19;
    // Width of a product of a sample and a coefficient.
    localparam int PROD_W    = CUR_W + COEF_W;
    // Width of a sum of three products.
    localparam int SUM_W     = PROD_W + 2;

    // Fixed-point coefficients, scaled by 2**COEF_FRAC.
    localparam logic signed [COEF_W-1:0] K_ZERO      = 19'sh00000;
    localparam logic signed [COEF_W-1:0] K_ONE       = 19'sh10000;
    localparam logic signed [COEF_W-1:0] K_THIRD     = 19'sh05555;
    localparam logic signed [COEF_W-1:0] K_TWO_THIRD = 19'sh0aaab;
    localparam logic signed [COEF_W-1:0] K_INV_RT3   = 19'sh093cd;
    localparam logic signed [COEF_W-1:0] K_TWO_RT3   = 19'sh1279a;

    // Number of 30 degree steps in a full turn.
    localparam logic [4:0] ANG_STEPS = 5'h0c;

    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] REG_CFG_W1 = 8'h00;
    localparam logic [7:0] REG_CFG_W2 = 8'h04;
    localparam logic [7:0] REG_CTRL   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;

    // Winding configuration register fields.
    localparam int CFG_CONN_LSB  = 0;
    localparam int CFG_ANG_LSB   = 2;
    localparam int CFG_GND_BIT   = 6;
    // Control register field: rotation ACB when set.
    localparam int CTRL_ACB_BIT  = 0;
    // Status register fields.
    localparam int STAT_REF_BIT  = 0;
    localparam int STAT_CMP1_LSB = 8;
    localparam int STAT_CMP2_LSB = 12;

    // Winding connection kinds; code 3 is reserved and acts as wye.
    typedef enum logic [1:0] {
        CONN_WYE    = 2'h0,
        CONN_DELTA  = 2'h1,
        CONN_ZIGZAG = 2'h2,
        CONN_RSVD   = 2'h3
    } tpzc_conn_e;

    // Settings of one winding.
    typedef struct packed {
        logic       gnd_in_zone;
        logic [3:0] angle;
        tpzc_conn_e conn;
    } tpzc_wcfg_s;

    // Reset value of a winding configuration: wye, angle 0, outside zone.
    localparam tpzc_wcfg_s WCFG_RST = '{gnd_in_zone: 1'b0, angle: 4'h0, conn: CONN_WYE};

    // Three uncompensated phase currents of one winding.
    typedef struct packed {
        logic signed [CUR_W-1:0] a;
        logic signed [CUR_W-1:0] b;
        logic signed [CUR_W-1:0] c;
    } tpzc_phase_s;

    // Three compensated phase currents of one winding.
    typedef struct packed {
        logic signed [OUT_W-1:0] a;
        logic signed [OUT_W-1:0] b;
        logic signed [OUT_W-1:0] c;
    } tpzc_cphase_s;

    // Weights on the own, next and previous phase for compensated phase A.
    typedef struct packed {
        logic signed [COEF_W-1:0] ka;
        logic signed [COEF_W-1:0] kb;
        logic signed [COEF_W-1:0] kc;
    } tpzc_coef_s;

endpackage

// [dv/tpzc_comp_props.sv]
// Concurrent checks on the ports of the compensation block.
// Assumes whole-word AHB-Lite writes and a single clock domain.
`timescale 1ns/100ps

module tpzc_comp_props
    import tpzc_pkg::*;
(
    // Clock and reset.
    input wire logic         hclk,
    input wire logic         hresetn,
    // Register bus.
    input wire logic         hsel,
    input wire logic [7:0]   haddr,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic [31:0]  hwdata,
    input wire logic         hready,
    input wire logic         hreadyout,
    input wire logic         hresp,
    // Sample streams.
    input wire logic         samp_valid,
    input wire tpzc_phase_s  samp_w1,
    input wire tpzc_phase_s  samp_w2,
    input wire logic         comp_valid,
    input wire tpzc_cphase_s comp_w1,
    input wire tpzc_cphase_s comp_w2
);
    logic              wp_q;   // A write data phase is under way.
    logic [7:0]        wa_q;   // Address of that write.
    logic [6:0]        cfg1_q; // Shadow of winding one settings.
    logic [6:0]        cfg2_q; // Shadow of winding two settings.
    logic [1:0]        quiet_q; // Edges since the settings last changed.
    logic              ref1;   // Winding one is the phase reference.
    logic              half;   // The windings sit half a turn apart.
    logic signed [19:0] sum1;  // Residual sum of winding one outputs.
    logic signed [19:0] sum2;  // Residual sum of winding two outputs.

    // Tracks the address phase of each write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= 1'b0;
            wa_q <= 8'h00;
        end else begin
            wp_q <= hsel && htrans[1] && hready && hwrite;
            wa_q <= haddr;
        end
    end

    // Shadows the settings so that checks know the mode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg1_q <= 7'h00;
            cfg2_q <= 7'h00;
            quiet_q <= 2'h0;
        end else if (wp_q && wa_q[7:2] <= 6'h02) begin
            if (wa_q[7:2] == 6'h00) cfg1_q <= hwdata[6:0];
            if (wa_q[7:2] == 6'h01) cfg2_q <= hwdata[6:0];
            quiet_q <= 2'h0;
        end else if (quiet_q != 2'h3) begin
            quiet_q <= quiet_q + 2'h1;
        end
    end

    // Connection codes one and two are the non-wye kinds.
    assign ref1 = ^cfg1_q[1:0] || !(^cfg2_q[1:0]);
    assign half = ((int'(cfg1_q[5:2]) % 12) + 18 - (int'(cfg2_q[5:2]) % 12)) % 12 == 0;
    assign sum1 = comp_w1.a + comp_w1.b + comp_w1.c;
    assign sum2 = comp_w2.a + comp_w2.b + comp_w2.c;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_strobe_answer: assert property (samp_valid |=> comp_valid)
        else $error("Strobe not answered.");
    a_answer_cause: assert property (comp_valid |-> $past(samp_valid))
        else $error("Output without strobe.");
    a_output_hold: assert property (!comp_valid |-> $stable(comp_w1) && $stable(comp_w2))
        else $error("Output moved between strobes.");
    a_zone_one: assert property (comp_valid && quiet_q >= 2'h2 && cfg1_q[6] |->
        sum1 >= -20'sd4 && sum1 <= 20'sd4)
        else $error("Zero-sequence left in winding one.");
    a_zone_two: assert property (comp_valid && quiet_q >= 2'h2 && cfg2_q[6] |->
        sum2 >= -20'sd4 && sum2 <= 20'sd4)
        else $error("Zero-sequence left in winding two.");
    a_ref_pass: assert property (comp_valid && quiet_q >= 2'h2 && ref1 && !cfg1_q[6] |->
        comp_w1.a == 18'($past(samp_w1.a)) && comp_w1.c == 18'($past(samp_w1.c)))
        else $error("Reference not passed.");
    a_half_turn: assert property (comp_valid && quiet_q >= 2'h2 && ref1 && half && !cfg2_q[6]
        |-> comp_w2.b == -18'($past(samp_w2.b)))
        else $error("Half-turn winding not negated.");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("Bus not ready or not OKAY.");
endmodule

bind tpzc_comp tpzc_comp_props u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .samp_valid, .samp_w1, .samp_w2, .comp_valid, .comp_w1, .comp_w2
);

// [dv/tpzc_front_model.sv]
// Stand-in for the measurement front end and the differential stage.
// Assumes one-cycle strobes in the same clock.
`timescale 1ns/100ps

module tpzc_front_model
    import tpzc_pkg::*;
(
    // Clock.
    input  wire logic         hclk,
    // Samples towards the block.
    output logic              samp_valid,
    output tpzc_phase_s       samp_w1,
    output tpzc_phase_s       samp_w2,
    // Compensated samples from the block.
    input  wire logic         comp_valid,
    input  wire tpzc_cphase_s comp_w1,
    input  wire tpzc_cphase_s comp_w2
);
    tpzc_cphase_s got_w1;      // Last compensated winding one sample.
    tpzc_cphase_s got_w2;      // Last compensated winding two sample.
    int           got_cnt = 0; // Number of compensated samples seen.

    // Lines idle low with no strobe at start.
    initial begin
        samp_valid = 1'b0;
        samp_w1 = '0;
        samp_w2 = '0;
    end

    // Sends one strobe, then shows the inverse on the lines.
    task automatic send(input tpzc_phase_s s1, input tpzc_phase_s s2);
        @(posedge hclk);
        samp_valid <= 1'b1;
        samp_w1 <= s1;
        samp_w2 <= s2;
        @(posedge hclk);
        samp_valid <= 1'b0;
        samp_w1 <= ~s1;
        samp_w2 <= ~s2;
    endtask

    // Captures each compensated sample as the differential stage would.
    always @(posedge hclk) begin
        if (comp_valid) begin
            got_w1 <= comp_w1;
            got_w2 <= comp_w2;
            got_cnt <= got_cnt + 1;
        end
    end
endmodule

// [dv/tpzc_comp_bench.sv]
// Self-checking bench for the compensation block.
// Assumes one bus master and the front-end model.
`timescale 1ns/100ps

module tpzc_comp_bench
    import tpzc_pkg::*;
;
    logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic         samp_valid, comp_valid;
    logic [7:0]   haddr;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  hwdata, hrdata, rd;
    tpzc_phase_s  samp_w1, samp_w2;
    tpzc_cphase_s comp_w1, comp_w2;
    int           mismatches = 0;
    int           tests_run = 0;

    // Weights (own, next, previous phase); row is 2*step + zone.
    // Codes: 1 one, 2 third, 3 two thirds, 4 inverse root three, 5 twice that.
    localparam int WT [24][3] = '{
        '{1, 0, 0}, '{3, -2, -2},
        '{4, 0, -4}, '{4, 0, -4},
        '{0, 0, -1}, '{2, 2, -3},
        '{-4, 0, -5}, '{0, 4, -4},
        '{0, 1, 0}, '{-2, 3, -2},
        '{-5, 0, -4}, '{-4, 4, 0},
        '{-1, 0, 0}, '{-3, 2, 2},
        '{-4, 0, 4}, '{-4, 0, 4},
        '{0, 0, 1}, '{-2, -2, 3},
        '{4, 0, 5}, '{0, -4, 4},
        '{0, -1, 0}, '{2, -3, 2},
        '{5, 0, 4}, '{4, -4, 0}
    };

    assign hready = hreadyout;

    tpzc_comp DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .samp_valid, .samp_w1, .samp_w2, .comp_valid, .comp_w1,
        .comp_w2);
    tpzc_front_model fe (.hclk, .samp_valid, .samp_w1, .samp_w2, .comp_valid, .comp_w1, .comp_w2);

    // A 40 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // Prints the counts and the verdict.
    task give_verdict;
        $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Counts one comparison and reports a difference.
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Ends the run when a wait runs out.
    task hang(input string nm);
        mismatches++;
        $display("MISMATCH %s expected done seen timeout", nm);
        give_verdict;
    endtask

    // Waits for an edge with hready high, within a bound.
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) hang("hready");
    endtask

    // One single word transfer: address phase, then data phase.
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
    endtask

    // Reads a register and compares it.
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(nm, exp, rd);
    endtask

    // Maps a weight code to its fixed-point value.
    function automatic longint kv(int c);
        longint m;
        case (c < 0 ? -c : c)
            1: m = K_ONE;
            2: m = K_THIRD;
            3: m = K_TWO_THIRD;
            4: m = K_INV_RT3;
            5: m = K_TWO_RT3;
            default: m = 0;
        endcase
        return (c < 0) ? -m : m;
    endfunction

    // Expected compensated phase from own, next and previous phase.
    function automatic logic signed [17:0] exp_ph(int k, int g, logic signed [15:0] o, n, p);
        longint s;
        s = kv(WT[2*k+g][0]) * o + kv(WT[2*k+g][1]) * n + kv(WT[2*k+g][2]) * p;
        return 18'(s >>> 16);
    endfunction

    // Compares the three phases of one winding; B and C rotate A's pattern.
    task chk_w(input string nm, input int k, g, input tpzc_phase_s s, input tpzc_cphase_s got);
        chk({nm, "a"}, 32'(exp_ph(k, g, s.a, s.b, s.c)), 32'(got.a));
        chk({nm, "b"}, 32'(exp_ph(k, g, s.b, s.c, s.a)), 32'(got.b));
        chk({nm, "c"}, 32'(exp_ph(k, g, s.c, s.a, s.b)), 32'(got.c));
    endtask

    // Programs both windings, checks the status and one compensated sample.
    task cfg_run(input logic [6:0] c1, c2, input logic acb, input int v);
        int r, a1, a2, ra, k1, k2, c0, n;
        tpzc_phase_s s1, s2;
        xfer(REG_CFG_W1, 1'b1, {25'h0, c1});
        xfer(REG_CFG_W2, 1'b1, {25'h0, c2});
        xfer(REG_CTRL, 1'b1, {31'h0, acb});
        a1 = c1[5:2] % 12;
        a2 = c2[5:2] % 12;
        r = (^c2[1:0] && !(^c1[1:0])) ? 1 : 0;
        ra = r ? a2 : a1;
        k1 = acb ? (a1 - ra + 12) % 12 : (ra - a1 + 12) % 12;
        k2 = acb ? (a2 - ra + 12) % 12 : (ra - a2 + 12) % 12;
        rdchk("status", REG_STATUS, {16'h0, 4'(k2), 4'(k1), 7'h0, 1'(r)});
        s1 = '{a: 16'(v), b: 16'(-3 * v), c: 16'(2 * v + 77)};
        s2 = '{a: 16'(5 * v - 9), b: 16'(v + 400), c: 16'(-7 * v)};
        c0 = fe.got_cnt;
        fe.send(s1, s2);
        n = 0;
        while (fe.got_cnt == c0 && n < 10) begin
            @(negedge hclk);
            n++;
        end
        if (fe.got_cnt == c0) hang("comp_valid");
        chk_w("w1.", k1, c1[6], s1, fe.got_w1);
        chk_w("w2.", k2, c2[6], s2, fe.got_w2);
        rdchk("held", REG_STATUS, {16'h0, 4'(k2), 4'(k1), 7'h0, 1'(r)});
    endtask

    // Registers read zero after reset.
    task t_zero;
        for (int i = 0; i < 16; i += 4) rdchk("reset", 8'(i), 32'h0);
    endtask

    // Unused bits, an unmapped place and the read-only status.
    task t_regs;
        xfer(8'h10, 1'b1, 32'hffffffff);
        rdchk("unmapped", 8'h10, 32'h0);
        xfer(REG_CFG_W1, 1'b1, 32'hffffffff);
        xfer(REG_CTRL, 1'b1, 32'hffffffff);
        xfer(REG_STATUS, 1'b1, 32'hffffffff);
        rdchk("cfg_w1", REG_CFG_W1, 32'h7f);
        rdchk("ctrl", REG_CTRL, 32'h1);
        rdchk("status", REG_STATUS, 32'h9000);
    endtask

    // Every angle step under both grounding settings.
    task t_angles;
        for (int g = 0; g < 2; g++) begin
            for (int k = 0; k < 12; k++) begin
                cfg_run({g[0], 4'h0, 2'h0}, {g[0], 4'((12 - k) % 12), 2'h0}, 1'b0, 1000 + 531 * k);
            end
        end
    endtask

    // Reference choice, rotation and angles past eleven.
    task t_ref;
        cfg_run(7'h00, 7'h05, 1'b0, -1234);
        cfg_run(7'h0e, 7'h15, 1'b0, 2222);
        cfg_run(7'h0b, 7'h1e, 1'b1, 321);
        cfg_run(7'h41, 7'h34, 1'b1, 4097);
        cfg_run(7'h10, 7'h46, 1'b1, -800);
        cfg_run(7'h3c, 7'h00, 1'b0, 4681);
    endtask

    // Main sequence, with a second reset in mid-run.
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_zero;
        t_regs;
        t_angles;
        t_ref;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_zero;
        give_verdict;
    end
endmodule
